//--- mid_misc_exec.sv
/*
  Decode and execute of accumulator-to-file, no-operation, configuration load
  and return-from-interrupt. Assumes the fetch path presents a new opcode with
  OP_VALID_IN at each Q1 and holds it for the instruction cycle; the stack and
  register file outside act on the one-cycle strobes driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_misc_exec (
  // Clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_IN,
  // Fetch path
  input  wire logic        OP_VALID_IN,
  input  wire logic [13:0] OPCODE_IN,
  input  wire logic [7:0]  ACC_IN,
  input  wire logic [12:0] STACK_TOP_ENTRY_IN,
  // Register file and stack
  output logic             FILE_WE_OUT,
  output logic [6:0]       FILE_ADR_OUT,
  output logic [7:0]       FILE_DATA_OUT,
  output logic             STACK_POP_OUT,
  output logic             PC_LOAD_OUT,
  output logic [12:0]      PC_OUT,
  output logic [7:0]       CFG_REG_OUT,
  output logic [7:0]       IRQ_CONTROL_REG_OUT,
  output logic             GLOBAL_IRQ_ENABLE_OUT,
  output logic             BUSY_OUT,
  output logic [1:0]       PHASE_OUT
);
  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  mid_dec_if dec_bus ();
  mid_opcode_dec u_dec (
    .opcode_in (OPCODE_IN),
    .dec       (dec_bus.dec)
  );

  // ----------------------------------------------------------------------
  // Quarter phase and instruction state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ACC2F, ST_CFG, ST_RET} mid_exec_t;

  mid_pkg::mid_phase_t phase_ff, nxt_phase;
  mid_exec_t           st_ff, nxt_st;
  logic                second_ff, nxt_second;
  logic [6:0]          adr_ff, nxt_adr;
  logic [7:0]          acc_ff, nxt_acc;
  logic                we_ff, nxt_we;
  logic [6:0]          fadr_ff, nxt_fadr;
  logic [7:0]          fdat_ff, nxt_fdat;
  logic                pop_ff, nxt_pop;
  logic                pcl_ff, nxt_pcl;
  logic [12:0]         pc_ff, nxt_pc;
  logic [7:0]          cfg_ff, nxt_cfg;
  logic [7:0]          irq_ff, nxt_irq;

  always_comb begin
    nxt_phase  = phase_ff;
    nxt_st     = st_ff;
    nxt_second = second_ff;
    nxt_adr    = adr_ff;
    nxt_acc    = acc_ff;
    nxt_we     = 1'b0;
    nxt_fadr   = fadr_ff;
    nxt_fdat   = fdat_ff;
    nxt_pop    = 1'b0;
    nxt_pcl    = 1'b0;
    nxt_pc     = pc_ff;
    nxt_cfg    = cfg_ff;
    nxt_irq    = irq_ff;
    case (phase_ff)
      mid_pkg::Q1: begin
        if (second_ff) begin
          nxt_phase = mid_pkg::Q2;
        end else if (OP_VALID_IN) begin
          nxt_phase = mid_pkg::Q2;
          nxt_adr   = dec_bus.file_adr;
          nxt_acc   = ACC_IN;
          // A no-op selects the idle path: address and accumulator are latched, but Q4 uses neither.
          if (dec_bus.is_nop) begin
            nxt_st = ST_IDLE;
          end else if (dec_bus.is_acc2f) begin
            nxt_st = ST_ACC2F;
          end else if (dec_bus.is_cfg_load) begin
            nxt_st = ST_CFG;
          end else if (dec_bus.is_ret_irq) begin
            nxt_st = ST_RET;
          end else begin
            nxt_st = ST_IDLE;
          end
        end
      end
      mid_pkg::Q2: begin
        nxt_phase = mid_pkg::Q3;
      end
      mid_pkg::Q3: begin
        nxt_phase = mid_pkg::Q4;
        if (st_ff == ST_RET && !second_ff) begin
          nxt_irq[mid_pkg::GIE_BIT] = 1'b1;
        end
      end
      mid_pkg::Q4: begin
        nxt_phase = mid_pkg::Q1;
        case (st_ff)
          ST_ACC2F: begin
            nxt_we   = 1'b1;
            nxt_fadr = adr_ff;
            nxt_fdat = acc_ff;
          end
          ST_CFG: begin
            nxt_cfg = acc_ff;
          end
          ST_RET: begin
            if (!second_ff) begin
              nxt_pop    = 1'b1;
              nxt_pcl    = 1'b1;
              nxt_pc     = STACK_TOP_ENTRY_IN;
              nxt_second = 1'b1;
            end else begin
              nxt_second = 1'b0;
              nxt_st     = ST_IDLE;
            end
          end
          default: begin
            nxt_st = ST_IDLE;
          end
        endcase
        if (st_ff != ST_RET) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_phase = mid_pkg::Q1;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      phase_ff  <= mid_pkg::Q1;
      st_ff     <= ST_IDLE;
      second_ff <= 1'b0;
      adr_ff    <= 7'h00;
      acc_ff    <= 8'h00;
      we_ff     <= 1'b0;
      fadr_ff   <= 7'h00;
      fdat_ff   <= 8'h00;
      pop_ff    <= 1'b0;
      pcl_ff    <= 1'b0;
      pc_ff     <= mid_pkg::PC_RESET;
      cfg_ff    <= mid_pkg::CFG_RESET;
      irq_ff    <= mid_pkg::IRQCTL_RESET;
    end else begin
      phase_ff  <= nxt_phase;
      st_ff     <= nxt_st;
      second_ff <= nxt_second;
      adr_ff    <= nxt_adr;
      acc_ff    <= nxt_acc;
      we_ff     <= nxt_we;
      fadr_ff   <= nxt_fadr;
      fdat_ff   <= nxt_fdat;
      pop_ff    <= nxt_pop;
      pcl_ff    <= nxt_pcl;
      pc_ff     <= nxt_pc;
      cfg_ff    <= nxt_cfg;
      irq_ff    <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Strobes appear one edge after the Q4 edge; the outside acts on them then.
  assign FILE_WE_OUT           = we_ff;
  assign FILE_ADR_OUT          = fadr_ff;
  assign FILE_DATA_OUT         = fdat_ff;
  assign STACK_POP_OUT         = pop_ff;
  assign PC_LOAD_OUT           = pcl_ff;
  assign PC_OUT                = pc_ff;
  assign CFG_REG_OUT           = cfg_ff;
  assign IRQ_CONTROL_REG_OUT   = irq_ff;
  assign GLOBAL_IRQ_ENABLE_OUT = irq_ff[mid_pkg::GIE_BIT];
  assign BUSY_OUT              = second_ff;
  assign PHASE_OUT             = phase_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_nop_no_write: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (phase_ff == mid_pkg::Q1 && !second_ff && OP_VALID_IN && dec_bus.is_nop)
      |-> ##1 (!nxt_we && !nxt_pop) [*4])
    else $error("no-op caused write or pop");
  a_nop_mask: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (OPCODE_IN[13:7] == 7'h00 && OPCODE_IN[4:0] == 5'h00) |-> dec_bus.is_nop)
    else $error("no-op variant not decoded");
  a_nop_one_cycle: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (phase_ff == mid_pkg::Q1 && !second_ff && OP_VALID_IN && dec_bus.is_nop)
      |-> ##4 (phase_ff == mid_pkg::Q1 && !second_ff))
    else $error("no-op took more than one cycle");
  // Compares the end of the no-op cycle with its decode edge, so that any
  // change made during Q2..Q4 is seen, not one made by the next instruction.
  a_nop_state_kept: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (phase_ff == mid_pkg::Q1 && !second_ff && OP_VALID_IN && dec_bus.is_nop)
      |-> ##4 (cfg_ff == $past(cfg_ff, 4) && irq_ff == $past(irq_ff, 4)
               && pc_ff == $past(pc_ff, 4) && fadr_ff == $past(fadr_ff, 4)
               && fdat_ff == $past(fdat_ff, 4)))
    else $error("no-op changed state");
  a_cfg_load: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (phase_ff == mid_pkg::Q1 && !second_ff && OP_VALID_IN && dec_bus.is_cfg_load)
      |-> ##4 (cfg_ff == $past(ACC_IN, 4)))
    else $error("configuration not loaded");
  a_ret_pop: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (phase_ff == mid_pkg::Q1 && !second_ff && OP_VALID_IN && dec_bus.is_ret_irq)
      |-> ##4 (pop_ff && pcl_ff && second_ff) ##1 (!pop_ff) [*4] ##0 !second_ff)
    else $error("return sequence wrong");
  a_ret_gie: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (phase_ff == mid_pkg::Q1 && !second_ff && OP_VALID_IN && dec_bus.is_ret_irq)
      |-> ##3 irq_ff[mid_pkg::GIE_BIT] ##1 pop_ff)
    else $error("enable not set before pop");
  a_acc2f_write: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (phase_ff == mid_pkg::Q1 && !second_ff && OP_VALID_IN && dec_bus.is_acc2f)
      |-> ##4 (we_ff && fdat_ff == $past(ACC_IN, 4) && fadr_ff == $past(OPCODE_IN[6:0], 4)))
    else $error("file write wrong");
endmodule : mid_misc_exec
`default_nettype wire

//--- mid_pkg.sv
/*
  Constants shared by the miscellaneous instruction decoder: opcode patterns,
  field positions, quarter phases and reset values.
  Assumes a 14-bit program word and an 8-bit data path.
*/
`default_nettype none
package mid_pkg;
  localparam int          OPC_W          = 14;
  localparam int          DAT_W          = 8;
  localparam int          FADR_W         = 7;
  localparam int          PC_W           = 13;
  // Accumulator-to-file: 00 0000 1fff ffff.
  localparam logic [6:0]  ACC2F_HI       = 7'h01;
  localparam int          ACC2F_HI_LSB   = 7;
  // No-operation: 00 0000 0xx0 0000, bits 6:5 ignored.
  localparam logic [13:0] NOP_MASK       = 14'h3f9f;
  localparam logic [13:0] NOP_CODE       = 14'h0000;
  localparam logic [13:0] CFG_LOAD_CODE  = 14'h0062;
  localparam logic [13:0] RET_IRQ_CODE   = 14'h0009;
  localparam int          GIE_BIT        = 7;
  localparam logic [7:0]  CFG_RESET      = 8'hff;
  localparam logic [7:0]  IRQCTL_RESET   = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET   = 13'h0000;
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} mid_phase_t;
endpackage : mid_pkg
`default_nettype wire

//--- mid_dec_if.sv
/*
  Interface carrying decoded instruction strobes from the opcode decoder to the
  executing core. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface mid_dec_if;
  logic       is_acc2f;
  logic       is_nop;
  logic       is_cfg_load;
  logic       is_ret_irq;
  logic [6:0] file_adr;
  modport dec (output is_acc2f, is_nop, is_cfg_load, is_ret_irq, file_adr);
  modport core (input is_acc2f, is_nop, is_cfg_load, is_ret_irq, file_adr);
endinterface : mid_dec_if
`default_nettype wire

//--- mid_opcode_dec.sv
/*
  Pure combinational opcode decoder for the four handled instructions.
  Assumes the opcode is stable from Q1 of an instruction cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_opcode_dec (
  input  wire logic [13:0] opcode_in,
  mid_dec_if.dec           dec
);
  always_comb begin
    dec.is_acc2f    = (opcode_in[13:mid_pkg::ACC2F_HI_LSB] == mid_pkg::ACC2F_HI);
    // Bits 6:5 are masked so every variant in the don't-care set is a no-op.
    dec.is_nop      = ((opcode_in & mid_pkg::NOP_MASK) == mid_pkg::NOP_CODE);
    dec.is_cfg_load = (opcode_in == mid_pkg::CFG_LOAD_CODE);
    dec.is_ret_irq  = (opcode_in == mid_pkg::RET_IRQ_CODE);
    dec.file_adr    = opcode_in[6:0];
  end
endmodule : mid_opcode_dec
`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench for the miscellaneous instruction decoder top.
  Assumes mid_pkg, mid_dec_if, mid_opcode_dec and mid_misc_exec compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        vld  = 1'b0;
  logic [13:0] op   = 14'h0000;
  logic [7:0]  acc  = 8'h00;
  logic [12:0] top  = 13'h0000;
  logic        we, pop, pcl, global_irq_enable, busy;
  logic [6:0]  adr;
  logic [7:0]  dat, cfg, irq;
  logic [12:0] pc;
  logic [1:0]  ph;
  logic [7:0]  e_cfg, e_irq;
  logic [12:0] e_pc;
  int          n_mismatch = 0;
  int          checked    = 0;

  always #2 mclk = ~mclk;

  mid_misc_exec dut (
    .MCLK_IN(mclk), .RESET_IN(rst), .OP_VALID_IN(vld), .OPCODE_IN(op), .ACC_IN(acc),
    .STACK_TOP_ENTRY_IN(top), .FILE_WE_OUT(we), .FILE_ADR_OUT(adr), .FILE_DATA_OUT(dat),
    .STACK_POP_OUT(pop), .PC_LOAD_OUT(pcl), .PC_OUT(pc), .CFG_REG_OUT(cfg),
    .IRQ_CONTROL_REG_OUT(irq), .GLOBAL_IRQ_ENABLE_OUT(global_irq_enable), .BUSY_OUT(busy), .PHASE_OUT(ph)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Kinds: 0 acc-to-file, 1 no-op, 2 config load, 3 return, 4 other opcode.
  function automatic logic [13:0] make_op(input int kind, input logic [13:0] r);
    case (kind)
      0:       make_op = {7'h01, r[6:0]};
      1:       make_op = {7'h00, r[1:0], 5'h00};
      2:       make_op = 14'h0062;
      3:       make_op = 14'h0009;
      default: make_op = {1'b1, r[12:0]};
    endcase
  endfunction : make_op

  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({we, pop, pcl, global_irq_enable, busy, ph}, 7'h00);
    chk({adr, dat}, 15'h0000);
    chk({cfg, irq, pc}, {mid_pkg::CFG_RESET, mid_pkg::IRQCTL_RESET, mid_pkg::PC_RESET});
    e_cfg = mid_pkg::CFG_RESET;
    e_irq = mid_pkg::IRQCTL_RESET;
    e_pc  = mid_pkg::PC_RESET;
  endtask : do_reset

  // Valid is held for four edges so exactly one Q1 edge sees it, whatever the
  // phase; timing is then judged against PHASE_OUT rather than a guessed edge.
  task automatic exec(input int kind, input logic [13:0] r, input logic [7:0] a,
                      input logic [12:0] t);
    int          nwe, npop, nbusy, kg, kp;
    logic        g0;
    logic [14:0] snap;
    nwe = 0;
    npop = 0;
    nbusy = 0;
    kg = 0;
    kp = 0;
    do @(negedge mclk); while (busy !== 1'b0);
    snap = {adr, dat};
    g0 = global_irq_enable;
    for (int k = 0; k < 14; k++) begin
      @(posedge mclk);
      vld <= (k < 4);
      op  <= (k < 4) ? make_op(kind, r) : 14'($urandom);
      acc <= (k < 4) ? a : 8'($urandom);
      top <= t;
      @(negedge mclk);
      if (we === 1'b1) begin
        nwe++;
        chk({ph, adr, dat}, {2'h0, r[6:0], a});
      end
      if (global_irq_enable === 1'b1 && g0 === 1'b0 && kg == 0) begin
        kg = k;
        chk(ph, 2'h3);
      end
      if (pop === 1'b1) begin
        npop++;
        kp = k;
        chk({pcl, pc, ph}, {1'b1, t, 2'h0});
      end
      if (busy === 1'b1) nbusy++;
    end
    chk(nwe, kind == 0);
    chk(npop, kind == 3);
    chk(nbusy, (kind == 3) ? 4 : 0);
    if (kind == 3 && g0 === 1'b0) chk(kp - kg, 1);
    if (kind == 2) e_cfg = a;
    if (kind == 3) begin
      e_irq[7] = 1'b1;
      e_pc = t;
    end
    chk({cfg, irq, global_irq_enable, pc}, {e_cfg, e_irq, e_irq[7], e_pc});
    if (kind != 0) chk({adr, dat}, snap);
  endtask : exec

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end

  initial begin
    void'($urandom(68455));
    do_reset();
    exec(3, 14'h0000, 8'h00, 13'h1abc);
    for (int i = 0; i < 4; i++) exec(1, 14'(i), 8'h5a, 13'h0001);
    exec(0, 14'h0000, 8'h00, 13'h0000);
    exec(0, 14'h007f, 8'hff, 13'h1fff);
    exec(2, 14'h0000, 8'h3c, 13'h0000);
    exec(4, 14'h0009, 8'h11, 13'h0000);
    do_reset();
    exec(3, 14'h0000, 8'h00, 13'h0fff);
    repeat (40) exec($urandom_range(4, 0), 14'($urandom), 8'($urandom), 13'($urandom));
    final_report();
  end
endmodule : tb_top
`default_nettype wire
